// ===== logic/bao_pkg.sv
// Constants and carrier types shared by the address offset latch files.
// Assumes one 100 MHz clock and 8-bit register addressing and data.
package bao_pkg;

  localparam logic [7:0] CFG_OFFSET = 8'h2B;
  localparam logic [7:0] I2C_BASE_OFFSET = 8'h32;
  localparam logic [7:0] SVID_BASE_OFFSET = 8'h33;
  localparam logic [7:0] READBACK_OFFSET = 8'hDB;
  localparam logic [7:0] TEST_OFFSET = 8'hF0;

  localparam int CFG_EN_BIT = 0;
  localparam int CFG_APPLY_I2C_BIT = 1;
  localparam int CFG_APPLY_SVID_BIT = 2;
  localparam int CMD_RELOAD_BIT = 4;

  localparam logic [2:0] CFG_RESET = 3'h7;
  localparam logic [6:0] I2C_BASE_RESET = 7'h44;
  localparam logic [3:0] SVID_BASE_RESET = 4'h0;
  localparam logic [7:0] TEST_RESET = 8'h00;

  localparam int I2C_WIDTH = 7;
  localparam int SVID_WIDTH = 4;
  localparam int STEP_WIDTH = 4;
  localparam int OFFSET_WIDTH = 4;

  localparam logic [3:0] HIGH_STRAP_FIRST = 4'h4;
  localparam logic [3:0] HIGH_STRAP_LAST = 4'h7;
  localparam logic [3:0] HIGH_STRAP_VALUE = 4'h8;
  localparam logic [3:0] LOW_STRAP_LAST = 4'h7;

  typedef struct packed {
    logic applySvid;
    logic applyI2c;
    logic enOffset;
  } bao_cfg_s;

  typedef struct packed {
    bao_cfg_s cfg;
    logic [6:0] i2cBase;
    logic [3:0] svidBase;
  } bao_nvm_s;

  typedef struct packed {
    logic [6:0] i2cAddr;
    logic [3:0] svidAddr;
  } bao_addr_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DISABLED,
    ST_LOAD,
    ST_CAPTURE,
    ST_RUN
  } bao_state_e;

endpackage : bao_pkg

// ===== logic/bao_strap_decode.sv
// Turns one strap pin's resistance step index into an address offset.
// Assumes step k stands for k times 20 kilo-ohm, and 9 and up for open.
`timescale 1ns/100ps
module bao_strap_decode #(
  parameter bit HIGH_PIN = 1'b0
) (
  input wire logic [bao_pkg::STEP_WIDTH-1:0] step,
  output logic [bao_pkg::OFFSET_WIDTH-1:0] offset
);

  // Step 8 lies between the documented bands; it is read as zero.
  always_comb
  begin
    offset = '0;
    if (HIGH_PIN)
    begin
      if (step >= bao_pkg::HIGH_STRAP_FIRST &&
          step <= bao_pkg::HIGH_STRAP_LAST)
        offset = bao_pkg::HIGH_STRAP_VALUE;
    end
    else if (step <= bao_pkg::LOW_STRAP_LAST)
    begin
      offset = step;
    end
  end

endmodule : bao_strap_decode

// ===== logic/bao_addr_wrap.sv
// Adds the held offset to one base address, wrapping at the field width.
// When apply is low the base passes through and the offset is ignored.
`timescale 1ns/100ps
module bao_addr_wrap #(
  parameter int WIDTH = 7
) (
  input wire logic [WIDTH-1:0] base,
  input wire logic [bao_pkg::OFFSET_WIDTH-1:0] offset,
  input wire logic apply,
  output logic [WIDTH-1:0] addr
);

  logic [WIDTH:0] sum;

  always_comb
  begin
    sum = {1'b0, base} + (WIDTH+1)'(offset);
    // The carry is dropped on purpose so that large sums wrap.
    addr = apply ? sum[WIDTH-1:0] : base;
  end

endmodule : bao_addr_wrap

// ===== logic/bao_offset_latch.sv
// Address strap latch: captures the strap offset at power-up or reload and
// applies it to the two-wire and voltage-ID addresses.
// Assumes a two-wire engine outside drives the register port and decodes
// power control commands, and that the analog front end gives step indices.
`timescale 1ns/100ps

// Notes on behaviour
// - The offset circuit starts enabled and is off when config bit 0 is 0.
// - When enabled the straps are sensed at power-up and the offset applied.
// - An address sum that overflows wraps around rather than saturating.
// - The high strap gives 8 for 80 to 140 kilo-ohm and 0 otherwise.
// - The low strap gives one per 20 kilo-ohm up to 7, and 0 above 160.
// - The two strap contributions add to a total offset from 0 to 15.
// - The total is captured once in the step after memory load and then held.
// - Plain enable and disable commands neither change nor recapture it.
// - Only a power cycle or a reload command captures the offset again.
// - The held offset reads back in bits 3 to 0 of register 219.
// - Register 43 holds voltage-ID apply, two-wire apply and enable bits.
// - The two-wire base is 7 bits in register 50, default 68.
// - A reload command disables, clears test state and reloads memory.
module bao_offset_latch (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic powerUp,
  input wire bao_pkg::bao_nvm_s nvmImage,
  input wire logic [bao_pkg::STEP_WIDTH-1:0] highStrapPin,
  input wire logic [bao_pkg::STEP_WIDTH-1:0] lowStrapPin,
  input wire logic powerCmdValid,
  input wire logic [7:0] powerCmd,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output bao_pkg::bao_addr_s busAddr,
  output logic [bao_pkg::OFFSET_WIDTH-1:0] heldOffset,
  output logic vrEnabled,
  output logic loadBusy
);

  bao_pkg::bao_state_e state_reg;
  bao_pkg::bao_state_e state_next;
  bao_pkg::bao_cfg_s cfg_reg;
  logic [6:0] i2cBase_reg;
  logic [3:0] svidBase_reg;
  logic [7:0] test_reg;
  logic [bao_pkg::OFFSET_WIDTH-1:0] offset_reg;
  logic vrEnabled_reg;
  logic reloadCmd;
  logic enableCmd;
  logic [bao_pkg::OFFSET_WIDTH-1:0] highOffset;
  logic [bao_pkg::OFFSET_WIDTH-1:0] lowOffset;
  logic [bao_pkg::OFFSET_WIDTH-1:0] strapSum;
  logic [6:0] i2cAddr;
  logic [3:0] svidAddr;
  logic [7:0] readMux;
  logic loading;
  logic running;
  logic captureNow;
  logic cfgWrite;
  logic i2cBaseWrite;
  logic svidBaseWrite;
  logic testWrite;
  logic i2cApplied;
  logic svidApplied;

  assign reloadCmd = powerCmdValid && powerCmd[bao_pkg::CMD_RELOAD_BIT];
  assign enableCmd = powerCmdValid && !powerCmd[bao_pkg::CMD_RELOAD_BIT];
  assign loading = (state_reg == bao_pkg::ST_LOAD);
  assign running = (state_reg == bao_pkg::ST_RUN);
  assign captureNow = (state_reg == bao_pkg::ST_CAPTURE);

  // The config and base registers only take software writes in the run state, so a
  // write that races a reload cannot survive the memory copy.
  assign cfgWrite = regWrite && running && regAddr == bao_pkg::CFG_OFFSET;
  assign i2cBaseWrite = regWrite && running &&
    regAddr == bao_pkg::I2C_BASE_OFFSET;
  assign svidBaseWrite = regWrite && running &&
    regAddr == bao_pkg::SVID_BASE_OFFSET;
  assign testWrite = regWrite && regAddr == bao_pkg::TEST_OFFSET;

  assign i2cApplied = cfg_reg.enOffset && cfg_reg.applyI2c;
  assign svidApplied = cfg_reg.enOffset && cfg_reg.applySvid;

  bao_strap_decode #(
    .HIGH_PIN(1'b1)
  ) highDecode (
    .step(highStrapPin),
    .offset(highOffset)
  );

  bao_strap_decode #(
    .HIGH_PIN(1'b0)
  ) lowDecode (
    .step(lowStrapPin),
    .offset(lowOffset)
  );

  // The high strap only ever gives 0 or 8 and the low one 0 to 7, so the
  // four-bit sum cannot overflow.
  assign strapSum = highOffset + lowOffset;

  // Every power-up and every reload passes through the same load and
  // capture steps, so the straps are only ever read at one place.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bao_pkg::ST_IDLE:
      begin
        if (powerUp)
          state_next = bao_pkg::ST_LOAD;
      end
      bao_pkg::ST_DISABLED:
      begin
        state_next = bao_pkg::ST_LOAD;
      end
      bao_pkg::ST_LOAD:
      begin
        state_next = bao_pkg::ST_CAPTURE;
      end
      bao_pkg::ST_CAPTURE:
      begin
        state_next = bao_pkg::ST_RUN;
      end
      bao_pkg::ST_RUN:
      begin
        if (reloadCmd)
          state_next = bao_pkg::ST_DISABLED;
      end
      default:
      begin
        state_next = bao_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= bao_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Working registers take their memory image at every load, and software
  // writes only land once the load sequence has finished.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cfg_reg <= bao_pkg::CFG_RESET;
    else if (loading)
      cfg_reg <= nvmImage.cfg;
    else if (cfgWrite)
      cfg_reg <= regWdata[2:0];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      i2cBase_reg <= bao_pkg::I2C_BASE_RESET;
    else if (loading)
      i2cBase_reg <= nvmImage.i2cBase;
    else if (i2cBaseWrite)
      i2cBase_reg <= regWdata[6:0];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      svidBase_reg <= bao_pkg::SVID_BASE_RESET;
    else if (loading)
      svidBase_reg <= nvmImage.svidBase;
    else if (svidBaseWrite)
      svidBase_reg <= regWdata[3:0];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      test_reg <= bao_pkg::TEST_RESET;
    else if (state_reg == bao_pkg::ST_DISABLED)
      test_reg <= bao_pkg::TEST_RESET;
    else if (testWrite)
      test_reg <= regWdata;
  end

  // The offset is touched only in the capture step; enable and disable
  // commands never reach it.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      offset_reg <= '0;
    else if (captureNow)
      offset_reg <= cfg_reg.enOffset ? strapSum : '0;
  end

  // The regulator reads as off from the load step after a disable until the capture has
  // landed, one cycle before the registered bus addresses take the new offset.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      vrEnabled_reg <= 1'b0;
    else if (state_reg == bao_pkg::ST_DISABLED ||
             state_reg == bao_pkg::ST_IDLE)
      vrEnabled_reg <= 1'b0;
    else if (captureNow)
      vrEnabled_reg <= 1'b1;
    else if (enableCmd && running)
      vrEnabled_reg <= |powerCmd[2:0];
  end

  bao_addr_wrap #(
    .WIDTH(bao_pkg::I2C_WIDTH)
  ) i2cWrap (
    .base(i2cBase_reg),
    .offset(offset_reg),
    .apply(i2cApplied),
    .addr(i2cAddr)
  );

  bao_addr_wrap #(
    .WIDTH(bao_pkg::SVID_WIDTH)
  ) svidWrap (
    .base(svidBase_reg),
    .offset(offset_reg),
    .apply(svidApplied),
    .addr(svidAddr)
  );

  // The effective addresses come from flip-flops so that the bus engines
  // never see a glitch while base and offset settle.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      busAddr.i2cAddr <= bao_pkg::I2C_BASE_RESET;
      busAddr.svidAddr <= bao_pkg::SVID_BASE_RESET;
    end
    else
    begin
      busAddr.i2cAddr <= i2cAddr;
      busAddr.svidAddr <= svidAddr;
    end
  end

  // Unmapped addresses read as zero, so a host probing the bus never sees
  // stale data from another register.
  always_comb
  begin
    readMux = 8'h00;
    case (regAddr)
      bao_pkg::CFG_OFFSET:
      begin
        readMux = {5'h00, cfg_reg};
      end
      bao_pkg::I2C_BASE_OFFSET:
      begin
        readMux = {1'b0, i2cBase_reg};
      end
      bao_pkg::SVID_BASE_OFFSET:
      begin
        readMux = {4'h0, svidBase_reg};
      end
      bao_pkg::READBACK_OFFSET:
      begin
        readMux = {4'h0, offset_reg};
      end
      bao_pkg::TEST_OFFSET:
      begin
        readMux = test_reg;
      end
      default:
      begin
        readMux = 8'h00;
      end
    endcase
  end

  // Writes to the readback address fall through and change nothing.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      regRvalid <= 1'b0;
    else
      regRvalid <= regRead;
  end

  // Read data stay put between reads, so a slow host may take them late.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= readMux;
  end

  assign heldOffset = offset_reg;
  assign vrEnabled = vrEnabled_reg;
  assign loadBusy = (state_reg != bao_pkg::ST_RUN);

endmodule : bao_offset_latch

// ===== tb/bao_offset_latch_assertions.sv
// Checker for the address offset latch top module ports.
// Assumes it is bound to every instance of bao_offset_latch.
`timescale 1ns/100ps
module bao_offset_latch_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic powerCmdValid,
  input wire logic [7:0] powerCmd,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  input wire logic [3:0] heldOffset,
  input wire logic vrEnabled,
  input wire logic loadBusy
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  wire cmdOk = powerCmdValid && !loadBusy;
  property p_read;
    regRead && regAddr == 8'hDB |=> regRvalid && regRdata == {4'h0, heldOffset};
  endproperty
  a_read: assert property (p_read) else $error("readback wrong");
  property p_rvalid;
    regRvalid |-> $past(regRead);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("stray rvalid");
  property p_hold;
    !loadBusy && !$past(loadBusy) |-> $stable(heldOffset);
  endproperty
  a_hold: assert property (p_hold) else $error("offset moved");
  property p_change;
    $changed(heldOffset) |-> $past(loadBusy);
  endproperty
  a_change: assert property (p_change) else $error("offset relatched");
  property p_keep;
    cmdOk && !powerCmd[4] |=> $stable(heldOffset) && !loadBusy;
  endproperty
  a_keep: assert property (p_keep) else $error("command relatched");
  property p_enable;
    cmdOk && !powerCmd[4] |=> vrEnabled == |($past(powerCmd) & 8'h07);
  endproperty
  a_enable: assert property (p_enable) else $error("enable wrong");
  property p_reload;
    cmdOk && powerCmd[4] |=> loadBusy [*3] ##1 !loadBusy;
  endproperty
  a_reload: assert property (p_reload) else $error("reload timing");
  property p_run;
    $fell(loadBusy) |-> vrEnabled;
  endproperty
  a_run: assert property (p_run) else $error("run without enable");
  c_reload: cover property (cmdOk && powerCmd[4]);
  c_read: cover property (regRvalid && regRdata == 8'h0F);
  c_off: cover property (cmdOk && powerCmd == 8'h00);
endmodule : bao_offset_latch_assertions

bind bao_offset_latch bao_offset_latch_assertions u_chk (
  .mclk(mclk), .nrst(nrst), .powerCmdValid(powerCmdValid),
  .powerCmd(powerCmd), .regRead(regRead), .regAddr(regAddr),
  .regRdata(regRdata), .regRvalid(regRvalid), .heldOffset(heldOffset),
  .vrEnabled(vrEnabled), .loadBusy(loadBusy)
);

// ===== tb/bao_strap_model.sv
// Strap resistor model: turns a resistance in kilo-ohm into a step index.
// Assumes the bench sets both resistances before the capture edge.
`timescale 1ns/100ps
module bao_strap_model (
  input int highKohm,
  input int lowKohm,
  output logic [3:0] highStep,
  output logic [3:0] lowStep
);
  // An open strap reads as step 9, just past the top of the table.
  function automatic logic [3:0] toStep(input int k);
    return (k > 160) ? 4'h9 : 4'(k / 20);
  endfunction : toStep
  assign highStep = toStep(highKohm);
  assign lowStep = toStep(lowKohm);
endmodule : bao_strap_model

// ===== tb/tb_bao_offset_latch.sv
// Bench for the address offset latch: power-up, reload and readback.
// Assumes the strap model feeds step indices and the bench drives the
// register and power control ports directly.
`timescale 1ns/100ps
module tb_bao_offset_latch;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic powerUp = 1'b0, powerCmdValid = 1'b0, regWrite = 1'b0;
  logic regRead = 1'b0, regRvalid, vrEnabled, loadBusy;
  logic [7:0] powerCmd = 8'h00, regAddr = 8'h00, regWdata = 8'h00;
  logic [7:0] regRdata, rdData;
  logic [3:0] hStep, lStep, heldOffset, e, ea, es;
  logic [2:0] cf;
  bao_pkg::bao_nvm_s nvmImage = {3'h7, 7'h77, 4'hE};
  bao_pkg::bao_addr_s busAddr;
  int hk = 0, lk = 0, n_mismatch = 0, num_checks = 0, cyc = 0;
  int tbl[6][3] = '{'{0, 0, 7}, '{80, 20, 6}, '{60, 140, 7},
    '{140, 140, 3}, '{200, 200, 7}, '{80, 40, 5}};

  bao_strap_model strap (.highKohm(hk), .lowKohm(lk), .highStep(hStep),
    .lowStep(lStep));
  bao_offset_latch dut (.mclk(mclk), .nrst(nrst), .powerUp(powerUp),
    .nvmImage(nvmImage), .highStrapPin(hStep), .lowStrapPin(lStep),
    .powerCmdValid(powerCmdValid), .powerCmd(powerCmd),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .busAddr(busAddr), .heldOffset(heldOffset), .vrEnabled(vrEnabled),
    .loadBusy(loadBusy));

  initial forever #5 mclk = ~mclk;

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // The run is about a hundred cycles, so this ceiling only catches a hang.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rd(input logic [7:0] a);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge mclk);
    regRead = 1'b0;
    rdData = regRdata;
    chk(regRvalid, 1'b1);
  endtask : rd

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask : wr

  task waitRun;
    for (int i = 0; i < 20 && loadBusy !== 1'b0; i++)
      @(negedge mclk);
    chk(loadBusy, 1'b0);
  endtask : waitRun

  task pulse(input logic up, input logic [7:0] c);
    @(negedge mclk);
    powerUp = up;
    powerCmdValid = !up;
    powerCmd = c;
    @(negedge mclk);
    powerUp = 1'b0;
    powerCmdValid = 1'b0;
    waitRun();
  endtask : pulse

  initial
  begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    for (int r = 0; r < 6; r++)
    begin
      hk = tbl[r][0];
      lk = tbl[r][1];
      cf = 3'(tbl[r][2]);
      nvmImage = {cf, 7'h77, 4'hE};
      pulse(r == 0, r[0] ? 8'h1A : 8'h1E);
      e = (hk >= 80 && hk <= 140) ? 4'h8 : 4'h0;
      e = e + ((lk <= 140) ? 4'(lk / 20) : 4'h0);
      e = cf[0] ? e : 4'h0;
      ea = cf[1] ? e : 4'h0;
      es = cf[2] ? e : 4'h0;
      rd(8'hDB);
      chk(rdData, {4'h0, e});
      chk(heldOffset, e);
      chk(busAddr.i2cAddr, 7'(7'h77 + ea));
      chk(busAddr.svidAddr, 4'(4'hE + es));
      $display("test strap row %0d done", r);
    end
    hk = 0;
    lk = 0;
    pulse(1'b0, 8'h00);
    chk(vrEnabled, 1'b0);
    pulse(1'b0, 8'h01);
    chk(vrEnabled, 1'b1);
    chk(heldOffset, 4'hA);
    $display("test power commands done");
    wr(8'hDB, 8'hFF);
    rd(8'hDB);
    chk(rdData, 8'h0A);
    rd(8'h10);
    chk(rdData, 8'h00);
    wr(8'h2B, 8'h03);
    wr(8'h32, 8'h7C);
    wr(8'h33, 8'h09);
    rd(8'h2B);
    chk(rdData, 8'h03);
    rd(8'h32);
    chk(rdData, 8'h7C);
    chk(busAddr.i2cAddr, 7'(7'h7C + 7'h0A));
    chk(busAddr.svidAddr, 4'h9);
    $display("test register access done");
    wr(8'hF0, 8'h5A);
    rd(8'hF0);
    chk(rdData, 8'h5A);
    pulse(1'b0, 8'h1A);
    rd(8'hF0);
    chk(rdData, 8'h00);
    chk(heldOffset, 4'h0);
    chk(busAddr.i2cAddr, 7'h77);
    chk(busAddr.svidAddr, 4'hE);
    $display("test reload done");
    hk = 140;
    lk = 140;
    nrst = 1'b0;
    repeat (5) @(negedge mclk);
    chk(heldOffset, 4'h0);
    nrst = 1'b1;
    pulse(1'b1, 8'h00);
    chk(heldOffset, 4'hF);
    $display("test power cycle done");
    test_done();
  end
endmodule : tb_bao_offset_latch
